// ### logic/skid_buffer.sv
// Two-entry valid/ready buffer between payload builder and thread dispatch.
// Assumes both sides run on aclk.
module skid_buffer
  import thread_payload_pkg::*;
#(
  parameter int WIDTH = 256,
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ### logic/thread_payload_builder.sv
// Geometry stage front end: object staging buffer and thread payload (R0) builder.
// Assumes an AXI4-Lite master on aclk and a dispatcher that drains thread_valid/ready.
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
module thread_payload_builder
  import thread_payload_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        vtx_valid,
  output      logic        vtx_ready,
  input  wire vertex_s     vtx,
  output      logic        thread_valid,
  input  wire logic        thread_ready,
  output      payload_s    thread_payload
);
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Register bus
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;
  logic        wr_hit;
  logic [31:0] ctrl_q;
  logic [31:0] bind_q;
  logic [31:0] sampler_q;
  logic [31:0] scratch_q;
  logic [31:0] handle_base_q;
  logic [31:0] debug_tid_q;
  logic [31:0] rd_val;
  logic        rd_hit;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_hit        = aw_addr_q[1:0] == 2'b00 && aw_addr_q <= DEBUG_TID_OFS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_addr_q    <= '0;
      w_data_q     <= '0;
      w_strb_q     <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q        <= CTRL_RST;
      bind_q        <= BIND_PTR_RST;
      sampler_q     <= SAMPLER_RST;
      scratch_q     <= SCRATCH_RST;
      handle_base_q <= HANDLE_BASE_RST;
      debug_tid_q   <= DEBUG_TID_RST;
    end else if (wr_fire && wr_hit) begin
      case (aw_addr_q)
        CTRL_OFS:        ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
        BIND_PTR_OFS:    bind_q <= merge(bind_q, w_data_q, w_strb_q);
        SAMPLER_OFS:     sampler_q <= merge(sampler_q, w_data_q, w_strb_q);
        SCRATCH_OFS:     scratch_q <= merge(scratch_q, w_data_q, w_strb_q);
        HANDLE_BASE_OFS: handle_base_q <= merge(handle_base_q, w_data_q, w_strb_q);
        DEBUG_TID_OFS:   debug_tid_q <= merge(debug_tid_q, w_data_q, w_strb_q);
        default: ;
      endcase
    end
  end

  logic [TID_W-1:0] tid_q;

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      CTRL_OFS:        rd_val = ctrl_q;
      BIND_PTR_OFS:    rd_val = bind_q;
      SAMPLER_OFS:     rd_val = sampler_q;
      SCRATCH_OFS:     rd_val = scratch_q;
      HANDLE_BASE_OFS: rd_val = handle_base_q;
      DEBUG_TID_OFS:   rd_val = debug_tid_q;
      STATUS_OFS:      rd_val = {8'h00, tid_q};
      default:         rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Object staging
  logic [1:0]       seen_q;
  logic             parity_q;
  logic             tag_q;
  logic [HANDLE_W-1:0] handle_q;
  logic [1:0]       need;
  logic             strip;
  logic             obj_done;
  logic             spawn;
  logic             buf_ready;
  logic [1:0]       seen_now;
  logic [4:0]       obj_code;
  logic [3:0]       scr_size;
  logic             snap;
  payload_s         build;

  always_comb begin
    need  = 2'd1;
    strip = 1'b0;
    case (vtx.topo)
      TOPO_LINELIST:     need = 2'd2;
      TOPO_LINESTRIP:    begin need = 2'd2; strip = 1'b1; end
      TOPO_TRILIST:      need = 2'd3;
      TOPO_TRISTRIP:     begin need = 2'd3; strip = 1'b1; end
      TOPO_TRISTRIP_REV: begin need = 2'd3; strip = 1'b1; end
      default:           need = 2'd1;
    endcase
  end

  // A stall downstream holds the vertex stream, so no object is dropped
  assign vtx_ready = buf_ready;
  assign seen_now  = vtx.first ? 2'd1 : ((seen_q == 2'd3) ? 2'd3 : seen_q + 2'd1);
  assign obj_done  = strip ? (seen_now >= need) : (seen_now == need);
  assign spawn     = vtx_valid && vtx_ready && obj_done && ctrl_q[CTRL_ENABLE_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_q   <= '0;
      parity_q <= 1'b0;
    end else if (vtx_valid && vtx_ready) begin
      seen_q <= (vtx.last || (!strip && obj_done)) ? 2'd0 : seen_now;
      if (vtx.first || vtx.last) begin
        parity_q <= vtx.last ? 1'b0 : (obj_done ? 1'b1 : 1'b0);
      end else if (obj_done) begin
        parity_q <= !parity_q;
      end
    end
  end

  always_comb begin
    obj_code = vtx.topo;
    if (parity_q && !vtx.first) begin
      if (vtx.topo == TOPO_TRISTRIP) begin
        obj_code = TOPO_TRISTRIP_REV;
      end else if (vtx.topo == TOPO_TRISTRIP_REV) begin
        obj_code = TOPO_TRISTRIP;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tid_q <= '0;
      tag_q <= 1'b0;
    end else if (spawn) begin
      tid_q <= tid_q + 1'b1;
      tag_q <= !tag_q;
    end
  end

  // A base write in the same cycle as a spawn wins; id and tag still advance so ids stay unique
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      handle_q <= '0;
    end else if (wr_fire && wr_hit && aw_addr_q == HANDLE_BASE_OFS) begin
      handle_q <= HANDLE_W'(merge(handle_base_q, w_data_q, w_strb_q));
    end else if (spawn) begin
      handle_q <= handle_q + 1'b1;
    end
  end

  // Out-of-range sizes are clamped rather than wrapped so a thread never overruns its slot
  assign scr_size = (sampler_q[3:0] > SCR_SIZE_MAX) ? SCR_SIZE_MAX : sampler_q[3:0];
  assign snap     = ctrl_q[CTRL_DEBUG_BIT] && (tid_q == debug_tid_q[TID_W-1:0]);

  always_comb begin
    build     = '0;
    build.dw7 = {snap, 31'h0};
    build.dw6 = {8'h00, tid_q};
    // Two tags share the area; the odd tag sits one allowance above the base
    build.dw5 = {scratch_q[31:PTR1K_LSB] + (tag_q ? (22'h1 << scr_size) : 22'h0), 9'h000, tag_q};
    build.dw4 = {bind_q[31:PTR32_LSB], 5'h00};
    // Clamped size passed; nothing here depends on it beyond slot placement
    build.dw3 = {sampler_q[31:PTR32_LSB], 1'b0, scr_size};
    build.dw2 = {27'h0, obj_code};
    build.dw1 = 32'h0;
    build.dw0 = {23'h0, handle_q};
  end

  skid_buffer #(
    .WIDTH ($bits(payload_s)),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (spawn),
    .in_ready  (buf_ready),
    .in_data   (build),
    .out_valid (thread_valid),
    .out_ready (thread_ready),
    .out_data  (thread_payload)
  );

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_spawn;
    spawn;
  endsequence
  // Strip pairs are only judged when the next object follows in the very next cycle
  sequence s_strip_pair;
    spawn && vtx.topo == TOPO_TRISTRIP && !vtx.last && build.dw2[4:0] == TOPO_TRISTRIP ##1 spawn;
  endsequence
  sequence s_rev_pair;
    spawn && vtx.topo == TOPO_TRISTRIP_REV && !vtx.last && build.dw2[4:0] == TOPO_TRISTRIP_REV ##1 spawn;
  endsequence
  sequence s_tri_start;
    vtx_valid && vtx_ready && vtx.first && !vtx.last && vtx.topo == TOPO_TRILIST
    ##1 vtx_valid && vtx_ready && !vtx.last;
  endsequence

  a_tid_step: assert property (s_spawn |=> tid_q == $past(tid_q) + 1'b1)
    else $error("thread id did not advance");
  a_tag_toggle: assert property (s_spawn |=> tag_q != $past(tag_q))
    else $error("thread tag did not toggle");
  a_no_spawn_idle: assert property (!(vtx_valid && vtx_ready) |=> tid_q == $past(tid_q))
    else $error("thread spawned without a vertex");
  a_spawn_off: assert property (!ctrl_q[CTRL_ENABLE_BIT] |=> tid_q == $past(tid_q))
    else $error("thread spawned while disabled");
  a_list_spawn: assert property (vtx_valid && vtx_ready && ctrl_q[CTRL_ENABLE_BIT] && vtx.first
                                 && vtx.topo == TOPO_POINTLIST |-> spawn)
    else $error("point did not spawn a thread");
  a_tri_hold: assert property (s_tri_start |-> !spawn)
    else $error("triangle spawned before third vertex");
  a_tri_spawn: assert property (s_tri_start ##1 vtx_valid && vtx_ready && ctrl_q[CTRL_ENABLE_BIT] |-> spawn)
    else $error("triangle did not spawn");
  a_snapshot_match: assert property (spawn |-> build.dw7[SNAPSHOT_BIT] ==
                                     (ctrl_q[CTRL_DEBUG_BIT] && tid_q == debug_tid_q[TID_W-1:0]))
    else $error("snapshot flag wrong");
  a_scratch_range: assert property (spawn |-> build.dw3[3:0] <= SCR_SIZE_MAX)
    else $error("scratch size out of range");
  a_reserved_zero: assert property (spawn |-> build.dw7[30:0] == 0 && build.dw6[31:24] == 0
                                    && build.dw5[9:1] == 0 && build.dw4[4:0] == 0 && build.dw3[4] == 0
                                    && build.dw2[31:5] == 0 && build.dw1 == 0 && build.dw0[31:9] == 0)
    else $error("reserved payload bit set");
  a_ptr_copy: assert property (spawn |-> build.dw4[31:5] == bind_q[31:5]
                               && build.dw3[31:5] == sampler_q[31:5])
    else $error("table pointer not copied");
  a_topo_default: assert property (spawn && vtx.topo != TOPO_TRISTRIP && vtx.topo != TOPO_TRISTRIP_REV
                                   |-> build.dw2[4:0] == vtx.topo)
    else $error("object code differs from topology");
  a_strip_alternate: assert property (s_strip_pair |-> build.dw2[4:0] == TOPO_TRISTRIP_REV)
    else $error("strip object code did not alternate");
  a_rev_alternate: assert property (s_rev_pair |-> build.dw2[4:0] == TOPO_TRISTRIP)
    else $error("reversed strip code did not alternate");
  a_handle_step: assert property (spawn && !(wr_fire && wr_hit && aw_addr_q == HANDLE_BASE_OFS)
                                  |=> handle_q == $past(handle_q) + 1'b1)
    else $error("return handle did not advance");
  a_handle_reload: assert property (wr_fire && wr_hit && aw_addr_q == HANDLE_BASE_OFS
                                    |=> handle_q == handle_base_q[HANDLE_W-1:0])
    else $error("return handle not reloaded");
  a_payload_hold: assert property (thread_valid && !thread_ready |=> thread_valid && $stable(thread_payload))
    else $error("stalled payload changed");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_bvalid_rise: assert property (wr_fire |=> s_axi_bvalid)
    else $error("write response missing");
  a_rvalid_rise: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
endmodule

// ### logic/thread_payload_pkg.sv
// Package for the geometry stage payload builder: register map, field layout, codes.
// Assumes a 32-bit AXI4-Lite register bus and a 125 MHz aclk.
package thread_payload_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] BIND_PTR_OFS    = 8'h04;
  localparam logic [7:0] SAMPLER_OFS     = 8'h08;
  localparam logic [7:0] SCRATCH_OFS     = 8'h0c;
  localparam logic [7:0] HANDLE_BASE_OFS = 8'h10;
  localparam logic [7:0] DEBUG_TID_OFS   = 8'h14;
  localparam logic [7:0] STATUS_OFS      = 8'h18;

  // Reset values
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
  localparam logic [31:0] BIND_PTR_RST    = 32'h0000_0000;
  localparam logic [31:0] SAMPLER_RST     = 32'h0000_0000;
  localparam logic [31:0] SCRATCH_RST     = 32'h0000_0000;
  localparam logic [31:0] HANDLE_BASE_RST = 32'h0000_0000;
  localparam logic [31:0] DEBUG_TID_RST   = 32'h0000_0000;

  // Control bits
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_DEBUG_BIT  = 1;

  // Field layout
  localparam int SNAPSHOT_BIT  = 31;
  localparam int TID_W         = 24;
  localparam int PTR1K_LSB     = 10;
  localparam int PTR32_LSB     = 5;
  localparam int SCR_SIZE_W    = 4;
  localparam int TOPO_W        = 5;
  localparam int HANDLE_W      = 9;
  localparam logic [3:0] SCR_SIZE_MAX = 4'hb;
  localparam int SCR_SIZE_BIAS = 10;

  // Topology codes
  localparam logic [4:0] TOPO_POINTLIST    = 5'h01;
  localparam logic [4:0] TOPO_LINELIST     = 5'h02;
  localparam logic [4:0] TOPO_LINESTRIP    = 5'h03;
  localparam logic [4:0] TOPO_TRILIST      = 5'h04;
  localparam logic [4:0] TOPO_TRISTRIP     = 5'h05;
  localparam logic [4:0] TOPO_TRISTRIP_REV = 5'h06;

  localparam int BUF_DEPTH = 2;

  typedef struct packed {
    logic       first;
    logic       last;
    logic [4:0] topo;
  } vertex_s;

  // Dwords of R0, highest first
  typedef struct packed {
    logic [31:0] dw7;
    logic [31:0] dw6;
    logic [31:0] dw5;
    logic [31:0] dw4;
    logic [31:0] dw3;
    logic [31:0] dw2;
    logic [31:0] dw1;
    logic [31:0] dw0;
  } payload_s;

endpackage

// ### sim/geometry_thread_payload_builder_test.sv
// Self-checking bench for the thread payload builder.
// Assumes the dispatcher model and the package are compiled first.
module geometry_thread_payload_builder_test
  import thread_payload_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, stall = 0, slow = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, vtx_valid = 0;
  logic awready, wready, bvalid, arready, rvalid, vtx_ready, thread_valid, thread_ready;
  logic [1:0] bresp, rresp, r;
  logic [31:0] d;
  vertex_s vtx = '0;
  payload_s thread_payload;
  payload_s exp_q[$];
  logic [31:0] ctrl_v, bind_v, smp_v, scr_v, dbg_v;
  logic [23:0] next_id = 0;
  logic [8:0] handle = 0;
  logic next_tag = 0;
  int num_errors = 0, n_checks = 0;
  always #4 aclk = !aclk;
  thread_payload_builder dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .vtx_valid(vtx_valid),
    .vtx_ready(vtx_ready), .vtx(vtx), .thread_valid(thread_valid), .thread_ready(thread_ready),
    .thread_payload(thread_payload));
  thread_dispatch_model dsp (.aclk(aclk), .aresetn(aresetn), .stall(stall), .slow(slow),
    .thread_valid(thread_valid), .thread_ready(thread_ready), .thread_payload(thread_payload));
  task automatic chk(input logic [255:0] got, input logic [255:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_ok, w_ok;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge aclk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (!(awvalid && !aw_ok) && !(wvalid && !w_ok)) break;
    end
    do begin
      @(negedge aclk);
    end while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ok;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ok = (arready === 1'b1);
      @(posedge aclk);
      if (ok) break;
    end
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
    end while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic send(input logic [4:0] code, input int n);
    logic ok;
    @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      vtx_valid <= 1'b1;
      vtx <= '{first: i == 0, last: i == n - 1, topo: code};
      forever begin
        @(negedge aclk);
        ok = (vtx_ready === 1'b1);
        @(posedge aclk);
        if (ok) break;
      end
    end
    vtx_valid <= 1'b0;
  endtask
  task automatic exp_thread(input logic [4:0] code);
    payload_s p;
    logic [3:0] sz;
    p = '0;
    // Payload carries the clamped exponent, so the odd-tag offset uses it too
    sz = (smp_v[3:0] > SCR_SIZE_MAX) ? SCR_SIZE_MAX : smp_v[3:0];
    p.dw7[SNAPSHOT_BIT] = ctrl_v[CTRL_DEBUG_BIT] && (next_id == dbg_v[23:0]);
    p.dw6[23:0] = next_id;
    p.dw5[31:10] = scr_v[31:10] + (next_tag ? (22'd1 << sz) : 22'd0);
    p.dw5[0] = next_tag;
    p.dw4[31:5] = bind_v[31:5];
    p.dw3 = {smp_v[31:5], 1'b0, sz};
    p.dw2[4:0] = code;
    p.dw0[8:0] = handle;
    exp_q.push_back(p);
    next_id++;
    next_tag = !next_tag;
    handle++;
  endtask
  task automatic drain();
    repeat (300) begin
      @(negedge aclk);
      if (dsp.got.size() >= exp_q.size()) break;
    end
    repeat (8) @(negedge aclk);
    chk(dsp.got.size(), exp_q.size(), "thread count");
    while (exp_q.size() > 0 && dsp.got.size() > 0) begin
      chk(dsp.got.pop_front(), exp_q.pop_front(), "payload");
    end
    exp_q.delete();
    dsp.got.delete();
  endtask
  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * i), d, r);
      chk({r, d}, 34'h0, "reset value");
    end
    rd(8'h1c, d, r);
    chk({r, d}, {2'b10, 32'h0}, "unmapped read");
    wr(STATUS_OFS, 32'h0000_0055, r);
    chk(r, 2'b10, "status write");
    $display("register test done");
  endtask
  task automatic t_cfg();
    bind_v = 32'h1234_5fff;
    smp_v = 32'habcd_e0ef;
    scr_v = 32'h00ff_fc00;
    dbg_v = 32'hff00_0003;
    ctrl_v = 32'h0000_0003;
    wr(BIND_PTR_OFS, bind_v, r);
    wr(SAMPLER_OFS, smp_v, r);
    wr(SCRATCH_OFS, scr_v, r);
    wr(DEBUG_TID_OFS, dbg_v, r);
    // Handle starts near the top of its range so the wrap is seen
    wr(HANDLE_BASE_OFS, 32'h0000_01fe, r);
    handle = 9'h1fe;
    wr(CTRL_OFS, ctrl_v, r);
    chk(r, 2'b00, "config write");
    rd(SAMPLER_OFS, d, r);
    chk(d, smp_v, "size kept as written");
    $display("config test done");
  endtask
  task automatic t_topo();
    logic [4:0] codes[7] = '{TOPO_POINTLIST, TOPO_LINELIST, TOPO_LINESTRIP, TOPO_TRILIST, TOPO_TRISTRIP,
                             TOPO_TRISTRIP_REV, 5'h1f};
    int lens[7] = '{2, 5, 3, 4, 5, 4, 2};
    int cnt;
    for (int i = 0; i < 7; i++) begin
      case (codes[i])
        TOPO_LINELIST: cnt = lens[i] / 2;
        TOPO_LINESTRIP: cnt = lens[i] - 1;
        TOPO_TRILIST: cnt = lens[i] / 3;
        TOPO_TRISTRIP, TOPO_TRISTRIP_REV: cnt = lens[i] - 2;
        default: cnt = lens[i];
      endcase
      for (int k = 0; k < cnt; k++) begin
        exp_thread((codes[i] inside {TOPO_TRISTRIP, TOPO_TRISTRIP_REV} && k % 2 == 1) ? codes[i] ^ 5'h03 : codes[i]);
      end
      send(codes[i], lens[i]);
      drain();
    end
    $display("topology test done");
  endtask
  task automatic t_stall();
    stall = 1'b1;
    for (int k = 0; k < 3; k++) exp_thread(TOPO_POINTLIST);
    fork
      send(TOPO_POINTLIST, 3);
    join_none
    repeat (20) @(negedge aclk);
    chk({thread_valid, vtx_ready}, 2'b10, "full buffer refuses");
    stall = 1'b0;
    slow = 1'b1;
    wait fork;
    drain();
    slow = 1'b0;
    rd(STATUS_OFS, d, r);
    chk(d, {8'h0, next_id}, "next thread id");
    $display("stall test done");
  endtask
  task automatic t_off();
    ctrl_v = 32'h0;
    wr(CTRL_OFS, ctrl_v, r);
    send(TOPO_TRILIST, 3);
    drain();
    rd(STATUS_OFS, d, r);
    chk(d, {8'h0, next_id}, "no id spent when off");
    $display("disable test done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    results();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_cfg();
    t_topo();
    t_stall();
    t_off();
    results();
  end
endmodule

// ### sim/thread_dispatch_model.sv
// Dispatcher stand-in that drains thread payloads into a queue.
// Assumes payloads arrive on aclk under valid/ready.
module thread_dispatch_model
  import thread_payload_pkg::*;
(
  input  wire logic     aclk,
  input  wire logic     aresetn,
  input  wire logic     stall,
  input  wire logic     slow,
  input  wire logic     thread_valid,
  output      logic     thread_ready,
  input  wire payload_s thread_payload
);
  timeunit 1ns;
  timeprecision 1ps;
  payload_s got[$];
  // Slow mode halves the drain rate so the buffer fills and empties
  always @(posedge aclk) begin
    if (!aresetn) begin
      thread_ready <= 1'b0;
    end else begin
      if (thread_valid && thread_ready) begin
        got.push_back(thread_payload);
      end
      thread_ready <= !stall && !(slow && thread_ready);
    end
  end
endmodule
